// ---- vdc_pkg.sv ----
// Shared constants for the supply-voltage detector control block.
package vdc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the APB window.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_GLOBAL = 8'h0c;

	////////////////////////////////////////////////////////////////////////////
	// Control register field positions.
	localparam int CTRL_DIR_BIT    = 7;
	localparam int CTRL_RSVD_BIT   = 6;
	localparam int CTRL_STABLE_BIT = 5;
	localparam int CTRL_EN_BIT     = 4;
	localparam int CTRL_LEVEL_MSB  = 3;

	// Control reset value: off, falling direction, level code 0101.
	localparam logic [7:0] CTRL_RESET = 8'h05;

	// Level code that hands the comparator to the external trip pin.
	localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;

	////////////////////////////////////////////////////////////////////////////
	// Status, mask and global register field positions.
	localparam int EVT_VOLTAGE_BIT = 0;
	localparam int EVT_STABLE_BIT  = 1;
	localparam int EVT_WIDTH       = 2;
	localparam int GLB_GIE_BIT     = 0;
	localparam int GLB_PRIO_BIT    = 1;

	////////////////////////////////////////////////////////////////////////////
	// Reference settling time and the derived cycle count, rounded up.
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SETTLE_TIME_US  = 20;
	localparam int SETTLE_CYCLES   = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Number of asynchronous analog inputs brought into the clock domain.
	localparam int SYNC_WIDTH = 3;

endpackage : vdc_pkg

// ---- vdc_sync_if.sv ----
`timescale 1ns/100ps
// Carries the raw analog levels to the synchroniser and the clean copies back.
interface vdc_sync_if #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic rstn
);
	logic [W-1:0] raw;
	logic [W-1:0] synced;

	modport sync (input clk, input rstn, input raw, output synced);
	modport user (output raw, input synced);

endinterface : vdc_sync_if

// ---- vdc_sync.sv ----
`timescale 1ns/100ps
// Two flip-flop synchroniser for the comparator and reference-ready levels.
module vdc_sync #(
	parameter int W = 3
) (
	vdc_sync_if.sync bus
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} vdc_sync_state_t;

	vdc_sync_state_t q;
	vdc_sync_state_t d;

	////////////////////////////////////////////////////////////////////////////
	// The first stage feeds only the second; nothing else may look at it.
	always_comb begin
		d        = q;
		d.stage1 = bus.raw;
		d.stage2 = q.stage1;
	end

	always_ff @(posedge bus.clk or negedge bus.rstn) begin
		if (!bus.rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.synced = q.stage2;

	////////////////////////////////////////////////////////////////////////////
	// A level reaches the user exactly two edges after it is sampled.
	sync_two_stage_a : assert property (@(posedge bus.clk) disable iff (!bus.rstn)
		##2 (bus.synced == $past(bus.raw, 2)))
		else $error("synchroniser latency is not two cycles");

endmodule : vdc_sync

// ---- vdc_top.sv ----
`timescale 1ns/100ps
// Contract
// - Direction bit 1 flags supply at or above trip; 0 flags at or below.
// - Read-only stable flag is 1 only once the detector has settled.
// - No voltage event or its interrupt before the stable flag is set.
// - Power enable 1 switches the detector on, 0 switches it off.
// - Each switch-on waits the settling interval; stable reads 0 meanwhile.
// - Four-bit level code picks one of fifteen settings, 0000 lowest, 1110 highest.
// - Level code 1111 routes the external trip pin to the comparator.
// - Comparator match in the chosen direction sets the voltage event flag.
// - Interrupt only when event enable and global enable are both set.
// - Settling interval is a fixed time; excursions during it may be missed.
// - Enabled detector keeps working in sleep; a crossing flags and wakes.
// - After a voltage wake, branch to vector only if globally enabled.
// - Any reset returns the control register to reset, detector off.
// - Bit between direction and stable ignores writes and reads zero.
module vdc_top #(
	parameter int SETTLE_CYC = vdc_pkg::SETTLE_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_above_i,
	input  wire logic        cmp_below_i,
	input  wire logic        ref_ready_i,
	input  wire logic        sleep_i,
	output logic             det_power_en_o,
	output logic      [3:0]  trip_level_o,
	output logic             ext_trip_sel_o,
	output logic             trip_dir_o,
	output logic             irq_o,
	output logic             irq_high_prio_o,
	output logic             wake_o,
	output logic             vector_o
);
	localparam int SCW = $clog2(SETTLE_CYC + 1);
	localparam int EW  = vdc_pkg::EVT_WIDTH;

	typedef struct packed {
		logic           trip_direction_select;
		logic           detector_power_enable;
		logic [3:0]     trip_level_select;
		logic           ext_sel;
		logic [SCW-1:0] settle;
		logic           reference_stable_flag;
		logic [EW-1:0]  status;
		logic [EW-1:0]  mask;
		logic           global_irq_enable;
		logic           voltage_event_priority;
		logic [31:0]    rdata;
		logic           ready;
		logic           slverr;
		logic           irq;
		logic           wake;
		logic           vector;
	} vdc_state_t;

	vdc_state_t q;
	vdc_state_t d;

	////////////////////////////////////////////////////////////////////////////
	// Analog levels arrive without any clock relation and are synchronised.
	vdc_sync_if #(.W(vdc_pkg::SYNC_WIDTH)) sync_bus (
		.clk  (clk),
		.rstn (rstn)
	);

	assign sync_bus.raw = {ref_ready_i, cmp_below_i, cmp_above_i};

	vdc_sync #(
		.W (vdc_pkg::SYNC_WIDTH)
	) u_sync (
		.bus (sync_bus)
	);

	logic above_s;
	logic below_s;
	logic ref_ok_s;

	// Only the second-stage copies are read from here on.
	assign above_s  = sync_bus.synced[0];
	assign below_s  = sync_bus.synced[1];
	assign ref_ok_s = sync_bus.synced[2];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode helpers.
	logic          setup_ph;
	logic          access_ph;
	logic          wr_ctrl;
	logic          wr_status;
	logic          wr_mask;
	logic          wr_global;
	logic          crossing;
	logic          voltage_hit;
	logic          stable_rise;
	logic [EW-1:0] evt_set;
	logic [EW-1:0] evt_clr;
	logic [7:0]    ctrl_byte;

	// The access is answered in the cycle after setup, so a write lands
	// at the single edge where the master sees pready high.
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable && q.ready;
	assign wr_ctrl   = access_ph && pwrite && (paddr == vdc_pkg::ADDR_CTRL);
	assign wr_status = access_ph && pwrite && (paddr == vdc_pkg::ADDR_STATUS);
	assign wr_mask   = access_ph && pwrite && (paddr == vdc_pkg::ADDR_MASK);
	assign wr_global = access_ph && pwrite && (paddr == vdc_pkg::ADDR_GLOBAL);

	// Bit 6 is hardwired low and the stable bit is never taken from a write.
	assign ctrl_byte = {q.trip_direction_select, 1'b0, q.reference_stable_flag,
		q.detector_power_enable, q.trip_level_select};

	// The direction bit chooses which comparator side counts as a crossing.
	assign crossing    = q.trip_direction_select ? above_s : below_s;
	assign voltage_hit = q.detector_power_enable && q.reference_stable_flag && crossing;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block.
	always_comb begin
		d             = q;
		d.ready       = 1'b0;
		d.slverr      = 1'b0;
		d.wake        = 1'b0;
		d.vector      = 1'b0;
		evt_clr       = '0;

		// Settling runs on a fixed time count; a power-off restarts it.
		if (!q.detector_power_enable) begin
			d.settle                = '0;
			d.reference_stable_flag = 1'b0;
		end else begin
			if (q.settle != SCW'(SETTLE_CYC)) begin
				d.settle = q.settle + 1'b1;
			end
			// Both the timer and the analog ready must agree before stable.
			d.reference_stable_flag = (q.settle == SCW'(SETTLE_CYC)) && ref_ok_s;
		end

		// Control writes; the stable bit and bit 6 are read-only.
		if (wr_ctrl) begin
			d.trip_direction_select = pwdata[vdc_pkg::CTRL_DIR_BIT];
			d.detector_power_enable = pwdata[vdc_pkg::CTRL_EN_BIT];
			d.trip_level_select     = pwdata[vdc_pkg::CTRL_LEVEL_MSB:0];
			if (!pwdata[vdc_pkg::CTRL_EN_BIT]) begin
				d.settle                = '0;
				d.reference_stable_flag = 1'b0;
			end
		end
		d.ext_sel = (d.trip_level_select == vdc_pkg::LEVEL_EXTERNAL);

		// Sticky events: set has priority over a write-one clear.
		stable_rise = d.reference_stable_flag && !q.reference_stable_flag;
		evt_set     = '0;
		evt_set[vdc_pkg::EVT_VOLTAGE_BIT] = voltage_hit;
		evt_set[vdc_pkg::EVT_STABLE_BIT]  = stable_rise;
		if (wr_status) begin
			evt_clr = pwdata[EW-1:0];
		end
		d.status = (q.status & ~evt_clr) | evt_set;

		if (wr_mask) begin
			d.mask = pwdata[EW-1:0];
		end
		if (wr_global) begin
			d.global_irq_enable      = pwdata[vdc_pkg::GLB_GIE_BIT];
			d.voltage_event_priority = pwdata[vdc_pkg::GLB_PRIO_BIT];
		end

		// The interrupt needs a masked-in event and the global enable.
		d.irq = d.global_irq_enable && |(d.status & d.mask);

		// A fresh voltage event during sleep wakes the core; it only takes
		// the vector when interrupts are globally allowed.
		if (sleep_i && d.status[vdc_pkg::EVT_VOLTAGE_BIT]
			&& !q.status[vdc_pkg::EVT_VOLTAGE_BIT]) begin
			d.wake   = 1'b1;
			d.vector = d.global_irq_enable && d.mask[vdc_pkg::EVT_VOLTAGE_BIT];
		end

		// Read data is captured in setup so it is ready in the access phase.
		if (setup_ph) begin
			d.ready = 1'b1;
			if (paddr == vdc_pkg::ADDR_CTRL) begin
				d.rdata = {24'h000000, ctrl_byte};
			end else if (paddr == vdc_pkg::ADDR_STATUS) begin
				d.rdata = {30'h0, q.status};
			end else if (paddr == vdc_pkg::ADDR_MASK) begin
				d.rdata = {30'h0, q.mask};
			end else if (paddr == vdc_pkg::ADDR_GLOBAL) begin
				d.rdata = {30'h0, q.voltage_event_priority, q.global_irq_enable};
			end else begin
				d.rdata  = 32'h00000000;
				d.slverr = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Any reset lands the control register on its reset value, detector off.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q                   <= '0;
			q.trip_level_select <= vdc_pkg::CTRL_RESET[3:0];
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state flip-flops.
	assign prdata          = q.rdata;
	assign pready          = q.ready;
	assign pslverr         = q.slverr;
	assign det_power_en_o  = q.detector_power_enable;
	assign trip_level_o    = q.trip_level_select;
	assign ext_trip_sel_o  = q.ext_sel;
	assign trip_dir_o      = q.trip_direction_select;
	assign irq_o           = q.irq;
	assign irq_high_prio_o = q.voltage_event_priority;
	assign wake_o          = q.wake;
	assign vector_o        = q.vector;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	int unsigned on_cnt;

	// Cycles since the detector was last switched on, saturating.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			on_cnt <= 0;
		end else if (!q.detector_power_enable) begin
			on_cnt <= 0;
		end else if (on_cnt < 32'd100000) begin
			on_cnt <= on_cnt + 1;
		end
	end

	high_dir_event_a : assert property (
		(q.detector_power_enable && q.reference_stable_flag && q.trip_direction_select
		&& above_s) |=> q.status[vdc_pkg::EVT_VOLTAGE_BIT])
		else $error("rising-direction crossing did not set the event flag");

	low_dir_event_a : assert property (
		(q.detector_power_enable && q.reference_stable_flag && !q.trip_direction_select
		&& below_s) |=> q.status[vdc_pkg::EVT_VOLTAGE_BIT])
		else $error("falling-direction crossing did not set the event flag");

	event_needs_stable_a : assert property (
		$rose(q.status[vdc_pkg::EVT_VOLTAGE_BIT]) |-> $past(q.reference_stable_flag))
		else $error("event flag rose without a stable reference");

	settle_wait_a : assert property (
		q.reference_stable_flag |-> (on_cnt > SETTLE_CYC))
		else $error("stable flag came before the settling interval");

	power_off_a : assert property (
		(wr_ctrl && !pwdata[vdc_pkg::CTRL_EN_BIT])
		|=> (!det_power_en_o && !q.reference_stable_flag))
		else $error("power-off write left the detector on or stable");

	ext_select_a : assert property (
		(wr_ctrl && (pwdata[3:0] == vdc_pkg::LEVEL_EXTERNAL)) |=> ext_trip_sel_o)
		else $error("level code 1111 did not select the external pin");

	irq_gate_a : assert property (
		irq_o |-> (q.global_irq_enable && |(q.status & q.mask)))
		else $error("interrupt raised without both enables");

	reserved_zero_a : assert property (
		(setup_ph && paddr == vdc_pkg::ADDR_CTRL)
		|=> (pready && !prdata[vdc_pkg::CTRL_RSVD_BIT] && prdata[31:8] == 24'h000000))
		else $error("reserved control bit read back non-zero");

	flag_sticky_a : assert property (
		(q.status[vdc_pkg::EVT_VOLTAGE_BIT] && !wr_status) |=> q.status[vdc_pkg::EVT_VOLTAGE_BIT])
		else $error("event flag dropped without a software clear");

	sleep_wake_a : assert property (
		(sleep_i && voltage_hit && !q.status[vdc_pkg::EVT_VOLTAGE_BIT]) |=> wake_o)
		else $error("crossing in sleep did not wake the core");

	vector_gate_a : assert property (
		vector_o |-> (wake_o && q.global_irq_enable))
		else $error("vector taken without the global enable");

	cover_event_c : cover property (
		$rose(q.status[vdc_pkg::EVT_VOLTAGE_BIT]) ##1 irq_o);
	cover_stable_c : cover property (
		$rose(det_power_en_o) ##[1:1000] $rose(q.reference_stable_flag));
	cover_wake_c : cover property (wake_o && vector_o);
	cover_ext_c : cover property (ext_trip_sel_o && q.status[vdc_pkg::EVT_VOLTAGE_BIT]);

endmodule : vdc_top

// ---- vdc_analog_model.sv ----
`timescale 1ns/100ps
// Behavioural divider, reference and comparator on the far side of the block.
module vdc_analog_model #(
	parameter int REF_DLY = 4
) (
	input  wire logic       clk,
	input  wire logic       power_en,
	input  wire logic [3:0] level,
	input  wire logic       ext_sel,
	input  int              supply_mv,
	input  int              ext_mv,
	output logic            above,
	output logic            below,
	output logic            ref_ready
);
	int cnt = 0;
	int trip;
	////////////////////////////////////////////////////////////////////////////
	// Reference start-up restarts on every switch-on, so a quick toggle is not stable.
	always @(posedge clk) begin
		if (!power_en)
			cnt <= 0;
		else if (cnt < REF_DLY)
			cnt <= cnt + 1;
	end
	// Outputs sit low while unpowered, as if pulled down, never a stale level.
	always_comb begin
		trip = ext_sel ? ext_mv : 2000 + 100 * level;
		ref_ready = power_en && cnt >= REF_DLY;
		above = ref_ready && supply_mv >= trip;
		below = ref_ready && supply_mv <= trip;
	end
endmodule : vdc_analog_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
// Register-level bench for the voltage detector control block.
module tb_top;
	logic        clk, rstn, psel, penable, pwrite, sleep_i, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        above, below, ref_rdy, pwr_en, ext_sel, dir, irq, wake, vec, prio;
	logic [3:0]  level;
	int          supply_mv, ext_mv, miscompares, checked, wakes, vecs;
	////////////////////////////////////////////////////////////////////////////
	vdc_top #(.SETTLE_CYC(8)) dut (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above_i(above),
		.cmp_below_i(below), .ref_ready_i(ref_rdy), .sleep_i(sleep_i),
		.det_power_en_o(pwr_en), .trip_level_o(level), .ext_trip_sel_o(ext_sel),
		.trip_dir_o(dir), .irq_o(irq), .irq_high_prio_o(prio), .wake_o(wake),
		.vector_o(vec));
	vdc_analog_model analog (.clk(clk), .power_en(pwr_en), .level(level),
		.ext_sel(ext_sel), .supply_mv(supply_mv), .ext_mv(ext_mv), .above(above),
		.below(below), .ref_ready(ref_rdy));
	////////////////////////////////////////////////////////////////////////////
	// Free-running system clock.
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Wake and vector are one-cycle pulses, so they are counted at every edge.
	always @(posedge clk) begin
		wakes <= wakes + (wake === 1'h1);
		vecs <= vecs + (vec === 1'h1);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic w8(input int n);
		repeat (n) @(posedge clk);
	endtask : w8
	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			check(pready, 1'h1);
			stop_test;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'h0, a, 32'h0);
		check(rd & m, exp);
	endtask : rdc
	// Watchdog well beyond the few hundred cycles the sequence needs.
	initial begin
		w8(20000);
		miscompares++;
		stop_test;
	end
	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{psel, penable, pwrite, sleep_i, rstn} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		supply_mv = 4000;
		ext_mv = 5000;
		{wakes, vecs, miscompares, checked} = '0;
		w8(20);
		rstn <= 1'h1;
		check(level, 4'h5);
		rdc(vdc_pkg::ADDR_CTRL, 32'h05, '1);
		rdc(8'h10, 32'h0, '1);
		check(err, 1'h1);
		wr(vdc_pkg::ADDR_CTRL, 32'hff);
		rdc(vdc_pkg::ADDR_CTRL, 32'h9f, '1);
		check({ext_sel, dir, pwr_en}, 3'h7);
		for (int i = 0; i < 16; i++) begin
			wr(vdc_pkg::ADDR_CTRL, i);
			w8(2);
			check({pwr_en, ext_sel, level}, {1'h0, i == 15, i[3:0]});
		end
		// Software order: off, level, direction, on, clear flag; supply already low.
		supply_mv <= 1000;
		wr(vdc_pkg::ADDR_CTRL, 32'h03);
		wr(vdc_pkg::ADDR_CTRL, 32'h13);
		wr(vdc_pkg::ADDR_STATUS, 32'h3);
		rdc(vdc_pkg::ADDR_CTRL, 32'h13, '1);
		rdc(vdc_pkg::ADDR_STATUS, 32'h0, 32'h1);
		w8(30);
		rdc(vdc_pkg::ADDR_CTRL, 32'h33, '1);
		rdc(vdc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		wr(vdc_pkg::ADDR_STATUS, 32'h1);
		rdc(vdc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		supply_mv <= 4000;
		w8(10);
		rdc(vdc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		wr(vdc_pkg::ADDR_STATUS, 32'h1);
		rdc(vdc_pkg::ADDR_STATUS, 32'h0, 32'h1);
		// Interrupt needs both the mask bit and the global enable.
		wr(vdc_pkg::ADDR_MASK, 32'h1);
		supply_mv <= 1000;
		w8(10);
		check(irq, 1'h0);
		wr(vdc_pkg::ADDR_GLOBAL, 32'h3);
		w8(2);
		check(irq, 1'h1);
		check(prio, 1'h1);
		wr(vdc_pkg::ADDR_MASK, 32'h0);
		w8(2);
		check(irq, 1'h0);
		// A high supply is no event while the falling direction is selected.
		supply_mv <= 4000;
		wr(vdc_pkg::ADDR_STATUS, 32'h1);
		rdc(vdc_pkg::ADDR_STATUS, 32'h0, 32'h1);
		// Rising direction, then the external pin as trip source.
		wr(vdc_pkg::ADDR_CTRL, 32'h93);
		w8(10);
		rdc(vdc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		wr(vdc_pkg::ADDR_CTRL, 32'h9f);
		w8(6);
		wr(vdc_pkg::ADDR_STATUS, 32'h3);
		w8(6);
		rdc(vdc_pkg::ADDR_STATUS, 32'h0, 32'h1);
		ext_mv <= 3000;
		w8(10);
		rdc(vdc_pkg::ADDR_STATUS, 32'h1, 32'h1);
		// Sleep: a crossing wakes; the vector follows only with the global enable.
		wr(vdc_pkg::ADDR_CTRL, 32'h13);
		wr(vdc_pkg::ADDR_MASK, 32'h1);
		w8(6);
		wr(vdc_pkg::ADDR_STATUS, 32'h3);
		sleep_i <= 1'h1;
		supply_mv <= 1000;
		w8(10);
		check(wakes, 32'd1);
		check(vecs, 32'd1);
		supply_mv <= 4000;
		wr(vdc_pkg::ADDR_GLOBAL, 32'h0);
		w8(6);
		check(prio, 1'h0);
		wr(vdc_pkg::ADDR_STATUS, 32'h3);
		supply_mv <= 1000;
		w8(10);
		check(wakes, 32'd2);
		check(vecs, 32'd1);
		sleep_i <= 1'h0;
		// Power off drops the stable flag at once.
		wr(vdc_pkg::ADDR_CTRL, 32'h03);
		rdc(vdc_pkg::ADDR_CTRL, 32'h03, '1);
		check(pwr_en, 1'h0);
		// A reset in mid-run returns the control register to its reset state.
		wr(vdc_pkg::ADDR_CTRL, 32'h9f);
		@(posedge clk);
		rstn <= 1'h0;
		@(posedge clk);
		rstn <= 1'h1;
		rdc(vdc_pkg::ADDR_CTRL, 32'h05, '1);
		check({pwr_en, irq}, 2'h0);
		stop_test;
	end
endmodule : tb_top
